// >>> verilog/qpsr_top.sv
// Per-queue peek and status register bank
// Function
// (RULE1) Entry count per counted queue, 19-bit read-only field.
// (RULE2) Count registers exist only for queues built with counting.
// (RULE3) Byte total per counted queue, 32-bit read-only field.
// (RULE4) Head packet size, 17 bits, zero when none was given.
// (RULE5) Threshold flag re-evaluated on every push and pop; refused pushes at full count and pops at zero skip it.
// (RULE6) Polarity set: flag when count >= threshold; cleared: count below.
// (RULE7) Code 0 gives 0, 10 or more 0x3FF, else 2^t-1.
// (RULE8) Software writes 0x81 for accumulator queues: flag on non-empty.
// (RULE9) Unused bits read zero, writes to them ignored.
// (RULE10) Level config writes only accepted from permitted requesters.
// (RULE11) Queue N registers at 16*N plus 0, 4, 8, 0xC.
// (RULE12) Level config register exists for every queue.
// (RULE13) Selected transmit queues drive a threshold pin from the flag.
// (RULE14) Push adds one and size; pop subtracts one and size.
// Assumes a queue engine giving push/pop events with the packet size on push and pop
// (plus size of new head on pop); at most one event per cycle; one clock.
//
// Our own choice: the address-and-strobe port.
`include "qpsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module qpsr_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`QPSR_AW-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr_allowed,
  output logic [31:0] bus_rdata,
  input wire logic evt_push,
  input wire logic evt_pop,
  input wire logic [`QPSR_QW-1:0] evt_qid,
  input wire logic [`QPSR_SIZE_W-1:0] evt_size,
  input wire logic [`QPSR_SIZE_W-1:0] evt_head_size,
  output logic [`QPSR_NQ-1:0] queue_level_flag,
  output logic [`QPSR_NQ-1:0] level_pin,
  output logic irq
);
  qpsr_pkg::qpsr_bus_t bus;
  qpsr_pkg::qpsr_evt_t ev;
  logic [`QPSR_CNT_W-1:0] tally_r [`QPSR_NQ];
  logic [`QPSR_BYTE_W-1:0] octet_r [`QPSR_NQ];
  qpsr_pkg::qpsr_level_t level_r [`QPSR_NQ];
  logic [`QPSR_NQ-1:0] flag_r;
  logic [`QPSR_NEVT-1:0] stat_r;
  logic [`QPSR_NEVT-1:0] mask_r;
  logic [`QPSR_NEVT-1:0] evt_set;
  logic [`QPSR_CNT_W-1:0] cnt_cur;
  logic [`QPSR_CNT_W-1:0] cnt_nxt;
  logic [`QPSR_BYTE_W-1:0] byte_cur;
  logic [`QPSR_BYTE_W-1:0] byte_nxt;
  logic [`QPSR_SIZE_W-1:0] head_wdata;
  logic [`QPSR_SIZE_W-1:0] head_rdata;
  logic [`QPSR_QW-1:0] rq;
  logic [3:0] roff;
  logic in_qarea;
  logic rd_d_r;
  logic [`QPSR_AW-1:0] raddr_r;
  logic [31:0] rword;
  logic is_counted;
  logic ev_any;
  logic ev_push_ok;
  logic ev_pop_ok;
  logic lvl_wr;
  logic [`QPSR_QW-1:0] wq;
  logic [`QPSR_NEVT-1:0] stat_seen_r;
  localparam logic [7:0] level_rst = `QPSR_LEVEL_RST;

  // =====================================
  // Threshold expansion and comparison
  function automatic logic [`QPSR_THR_W-1:0] thr_expand(
    input logic [`QPSR_CODE_W-1:0] code
  );
    logic [`QPSR_THR_W-1:0] v;
    v = '0;
    if (code == '0) begin
      v = '0; // [RULE7]
    end else if (code >= `QPSR_CODE_SAT) begin
      v = `QPSR_THR_MAX; // [RULE7]
    end else begin
      v = `QPSR_THR_W'((`QPSR_THR_W'(1) << code) - `QPSR_THR_W'(1)); // [RULE7]
    end
    return v;
  endfunction

  function automatic logic level_eval(
    input logic [`QPSR_CNT_W-1:0] cnt,
    input qpsr_pkg::qpsr_level_t cfg
  );
    logic ge;
    ge = cnt >= `QPSR_CNT_W'(thr_expand(cfg.code));
    return cfg.pol ? ge : !ge; // [RULE6]
  endfunction

  // =====================================
  // Bundle the ports
  assign bus.wr = bus_wr;
  assign bus.rd = bus_rd;
  assign bus.addr = bus_addr;
  assign bus.wdata = bus_wdata;
  assign bus.wr_allowed = bus_wr_allowed;
  assign ev.push = evt_push;
  assign ev.pop = evt_pop;
  assign ev.qid = evt_qid;
  assign ev.size = evt_size;

  // =====================================
  // Queue event arithmetic
  assign is_counted = ((`QPSR_COUNT_CAPS >> ev.qid) & 16'h0001) !=
                      16'h0000; // [RULE2]
  assign cnt_cur = tally_r[ev.qid];
  assign byte_cur = octet_r[ev.qid];
  assign ev_any = ev.push ^ ev.pop;
  // Refuse counts that would wrap
  assign ev_push_ok = ev_any && ev.push && !(&cnt_cur);
  assign ev_pop_ok = ev_any && ev.pop && (cnt_cur != '0);

  // Next count and byte total for the event queue
  always_comb begin
    cnt_nxt = cnt_cur;
    byte_nxt = byte_cur;
    if (ev_push_ok) begin
      cnt_nxt = cnt_cur + `QPSR_CNT_W'(1); // [RULE14]
      byte_nxt = byte_cur + `QPSR_BYTE_W'(ev.size); // [RULE14]
    end else if (ev_pop_ok) begin
      cnt_nxt = cnt_cur - `QPSR_CNT_W'(1); // [RULE14]
      byte_nxt = byte_cur - `QPSR_BYTE_W'(ev.size); // [RULE14]
    end
  end

  // Entry and byte counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < `QPSR_NQ; i++) begin
        tally_r[i] <= '0;
        octet_r[i] <= '0;
      end
    end else if (is_counted && (ev_push_ok || ev_pop_ok)) begin
      tally_r[ev.qid] <= cnt_nxt; // [RULE1] [RULE3]
      octet_r[ev.qid] <= byte_nxt;
    end
  end

  // Status flags, refreshed on push and pop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_r <= '0;
    end else if (ev_push_ok || ev_pop_ok) begin
      flag_r[ev.qid] <= level_eval(cnt_nxt, level_r[ev.qid]); // [RULE5]
    end
  end

  assign queue_level_flag = flag_r;
  assign level_pin = flag_r & `QPSR_PIN_QUEUES; // [RULE13]

  // =====================================
  // Head size memory: push onto empty or pop sets the new head
  assign head_wdata = ev.pop ? evt_head_size : ev.size;
  qpsr_head_ram u_head (
    .ref_clk(ref_clk),
    .we((ev_push_ok && cnt_cur == '0) || ev_pop_ok || reset),
    .waddr(reset ? rq : ev.qid),
    .wdata((reset || (ev_pop_ok && cnt_cur == `QPSR_CNT_W'(1))) ?
           '0 : head_wdata), // [RULE4]
    .raddr(rq),
    .rdata(head_rdata)
  );

  // =====================================
  // Register writes
  assign roff = bus.addr[3:0];
  assign rq = bus.addr[`QPSR_QW+`QPSR_STRIDE_SH-1:`QPSR_STRIDE_SH]; // [RULE11]
  assign in_qarea = bus.addr < `QPSR_QAREA_TOP;
  assign wq = rq;
  assign lvl_wr = bus.wr && in_qarea && roff == `QPSR_OFF_LEVEL;

  // Level config per queue, guarded write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < `QPSR_NQ; i++) begin
        level_r[i] <= qpsr_pkg::qpsr_level_t'({level_rst[`QPSR_POL_BIT],
                                              level_rst[`QPSR_CODE_W-1:0]});
      end
    end else if (lvl_wr && bus.wr_allowed) begin // [RULE10] [RULE12]
      level_r[wq].pol <= bus.wdata[`QPSR_POL_BIT]; // [RULE9]
      level_r[wq].code <= bus.wdata[`QPSR_CODE_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_r <= '0;
    end else if (bus.wr && bus.addr == `QPSR_OFF_IRQ_MASK) begin
      mask_r <= bus.wdata[`QPSR_NEVT-1:0];
    end
  end

  // =====================================
  // Interrupt events: wrap refusals and denied writes
  always_comb begin
    evt_set = '0;
    evt_set[`QPSR_EVT_OVR] = ev.push && !ev.pop && (&cnt_cur);
    evt_set[`QPSR_EVT_UND] = ev.pop && !ev.push && cnt_cur == '0;
    evt_set[`QPSR_EVT_WDENY] = lvl_wr && !bus.wr_allowed; // [RULE10]
  end

  // Sticky status, cleared by read, set wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stat_r <= '0;
    end else if (bus.rd && bus.addr == `QPSR_OFF_IRQ_STAT) begin
      stat_r <= evt_set;
    end else begin
      stat_r <= stat_r | evt_set;
    end
  end

  assign irq = |(stat_r & mask_r);

  // =====================================
  // Read path: capture address, answer next cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_d_r <= 1'b0;
      raddr_r <= '0;
      stat_seen_r <= '0;
    end else begin
      rd_d_r <= bus.rd;
      raddr_r <= bus.addr;
      stat_seen_r <= stat_r; // Status as seen before the clearing read
    end
  end

  // Read word mux; unused bits are zero
  always_comb begin
    logic [`QPSR_QW-1:0] q;
    logic cnt_ok;
    q = raddr_r[`QPSR_QW+`QPSR_STRIDE_SH-1:`QPSR_STRIDE_SH];
    cnt_ok = (`QPSR_COUNT_CAPS >> q & 16'h0001) != 16'h0000;
    rword = '0;
    if (raddr_r < `QPSR_QAREA_TOP) begin
      unique case (raddr_r[3:0])
        `QPSR_OFF_TALLY:
          rword = cnt_ok ? 32'(tally_r[q]) : '0; // [RULE1] [RULE9]
        `QPSR_OFF_OCTET:
          rword = cnt_ok ? octet_r[q] : '0; // [RULE3]
        `QPSR_OFF_HEAD:
          rword = (tally_r[q] == '0) ? '0 : 32'(head_rdata); // [RULE4]
        `QPSR_OFF_LEVEL:
          rword = {24'h000000, level_r[q].pol, 3'h0, level_r[q].code};
        default:
          rword = '0;
      endcase
    end else if (raddr_r == `QPSR_OFF_IRQ_STAT) begin
      rword = 32'(stat_seen_r);
    end else if (raddr_r == `QPSR_OFF_IRQ_MASK) begin
      rword = 32'(mask_r);
    end else if (raddr_r == `QPSR_OFF_CAPS) begin
      rword = {16'h0000, 16'(`QPSR_COUNT_CAPS)};
    end
  end

  // Read data from registered address and state, zero outside answer cycle
  always_comb begin
    bus_rdata = rd_d_r ? rword : '0; // [RULE9]
  end
endmodule
`default_nettype wire

// >>> verilog/qpsr_params.svh
// Constants for the queue peek and status register bank
// Assumes inclusion by bare name from the package and design files
`ifndef QPSR_PARAMS_SVH
`define QPSR_PARAMS_SVH

// =====================================
// Geometry
`define QPSR_NQ 16
`define QPSR_QW 4
`define QPSR_AW 10
`define QPSR_STRIDE_SH 4
// Per-queue register offsets within the stride
`define QPSR_OFF_TALLY 4'h0
`define QPSR_OFF_OCTET 4'h4
`define QPSR_OFF_HEAD 4'h8
`define QPSR_OFF_LEVEL 4'hC
// Block-wide registers above the queue area
`define QPSR_OFF_IRQ_STAT 10'h100
`define QPSR_OFF_IRQ_MASK 10'h104
`define QPSR_OFF_CAPS 10'h108
`define QPSR_QAREA_TOP 10'h100

// =====================================
// Field widths and positions
`define QPSR_CNT_W 19
`define QPSR_BYTE_W 32
`define QPSR_SIZE_W 17
`define QPSR_THR_W 10
`define QPSR_POL_BIT 7
`define QPSR_CODE_W 4
`define QPSR_LEVEL_RST 8'h81
`define QPSR_CODE_SAT 4'hA
`define QPSR_THR_MAX 10'h3FF
`define QPSR_NEVT 3
`define QPSR_EVT_OVR 0
`define QPSR_EVT_UND 1
`define QPSR_EVT_WDENY 2
// Queues built with counting: default all
`define QPSR_COUNT_CAPS 16'hFFFF
// Queues that drive a threshold pin
`define QPSR_PIN_QUEUES 16'h00FF

`endif

// >>> verilog/qpsr_pkg.sv
// Types for the queue peek and status register bank
// Assumes qpsr_params.svh on the include path
`include "qpsr_params.svh"

package qpsr_pkg;
  // One push or pop event from the queue engine
  typedef struct packed {
    logic push;
    logic pop;
    logic [`QPSR_QW-1:0] qid;
    logic [`QPSR_SIZE_W-1:0] size;
  } qpsr_evt_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`QPSR_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr_allowed;
  } qpsr_bus_t;

  // Threshold configuration per queue
  typedef struct packed {
    logic pol;
    logic [`QPSR_CODE_W-1:0] code;
  } qpsr_level_t;
endpackage

// >>> verilog/qpsr_head_ram.sv
// Small memory holding head packet size per queue, registered read
// Assumes one clock, synchronous writes, one read port
`include "qpsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module qpsr_head_ram (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [`QPSR_QW-1:0] waddr,
  input wire logic [`QPSR_SIZE_W-1:0] wdata,
  input wire logic [`QPSR_QW-1:0] raddr,
  output logic [`QPSR_SIZE_W-1:0] rdata
);
  logic [`QPSR_SIZE_W-1:0] mem [`QPSR_NQ];

  // =====================================
  // Write port
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> verification/qpsr_top_chk.sv
// Checker for the queue peek and status register bank
// Assumes the ports of qpsr_top and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "qpsr_params.svh"
module qpsr_top_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`QPSR_AW-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr_allowed,
  input wire logic [31:0] bus_rdata,
  input wire logic evt_push,
  input wire logic evt_pop,
  input wire logic [`QPSR_QW-1:0] evt_qid,
  input wire logic [`QPSR_SIZE_W-1:0] evt_size,
  input wire logic [`QPSR_SIZE_W-1:0] evt_head_size,
  input wire logic [`QPSR_NQ-1:0] queue_level_flag,
  input wire logic [`QPSR_NQ-1:0] level_pin,
  input wire logic irq
);
  // ==========
  // Address decodes
  wire in_q = bus_addr < `QPSR_QAREA_TOP;
  wire lvl = in_q && bus_addr[3:0] == 4'hC;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ==========
  // Properties
  property p_pin; level_pin == (queue_level_flag & 16'h00FF); endproperty
  a_pin: assert property (p_pin) else $error("pin mismatch");
  property p_rst; $fell(reset) |-> !queue_level_flag && !irq; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_evt; $changed(queue_level_flag) |-> $past(evt_push ^ evt_pop)
    && (queue_level_flag ^ $past(queue_level_flag)) == (16'h1 << $past(evt_qid));
  endproperty
  a_evt: assert property (p_evt) else $error("flag change");
  property p_tal; bus_rd && in_q && bus_addr[3:0] == 4'h0
    |=> bus_rdata[31:19] == '0; endproperty
  a_tal: assert property (p_tal) else $error("count upper");
  property p_hd; bus_rd && in_q && bus_addr[3:0] == 4'h8
    |=> bus_rdata[31:17] == '0; endproperty
  a_hd: assert property (p_hd) else $error("head upper");
  property p_lv; bus_rd && lvl
    |=> bus_rdata[31:8] == '0 && bus_rdata[6:4] == '0; endproperty
  a_lv: assert property (p_lv) else $error("config spare bits");
  property p_wr; bus_wr && bus_wr_allowed && lvl ##1 bus_rd && $stable(bus_addr)
    |=> bus_rdata[7:0] == ($past(bus_wdata[7:0], 2) & 8'h8F); endproperty
  a_wr: assert property (p_wr) else $error("config readback");
  property p_cap; bus_rd && bus_addr == `QPSR_OFF_CAPS
    |=> bus_rdata == {16'h0, `QPSR_COUNT_CAPS}; endproperty
  a_cap: assert property (p_cap) else $error("caps word");
  // Main scenarios
  c_push: cover property (evt_push ##1 $changed(queue_level_flag));
  c_deny: cover property (bus_wr && !bus_wr_allowed && lvl);
  c_irq: cover property ($rose(irq));
endmodule
bind qpsr_top qpsr_top_chk qpsr_top_chk_inst (.ref_clk, .reset, .bus_wr,
  .bus_rd, .bus_addr, .bus_wdata, .bus_wr_allowed, .bus_rdata, .evt_push,
  .evt_pop, .evt_qid, .evt_size, .evt_head_size, .queue_level_flag,
  .level_pin, .irq);
`default_nettype wire

// >>> verification/qpsr_engine_model.sv
// Queue engine model issuing push and pop events
// Assumes its task is called at a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "qpsr_params.svh"
module qpsr_engine_model (
  input wire logic ref_clk,
  output logic evt_push,
  output logic evt_pop,
  output logic [`QPSR_QW-1:0] evt_qid,
  output logic [`QPSR_SIZE_W-1:0] evt_size,
  output logic [`QPSR_SIZE_W-1:0] evt_head_size
);
  // ==========
  // Idle at time zero
  initial begin
    {evt_push, evt_pop, evt_qid, evt_size, evt_head_size} = '0;
  end
  // One event, then idle with the size fields inverted and the queue id kept
  task automatic send(input logic psh, input logic [`QPSR_QW-1:0] q,
      input logic [16:0] s, input logic [16:0] h);
    evt_push <= psh;
    evt_pop <= !psh;
    evt_qid <= q;
    evt_size <= s;
    evt_head_size <= h;
    @(posedge ref_clk);
    evt_push <= 1'b0;
    evt_pop <= 1'b0;
    evt_size <= ~s;
    evt_head_size <= ~h;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> verification/qpsr_top_tb.sv
// Testbench for the queue peek and status register bank
// Assumes qpsr_top, the engine model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "qpsr_params.svh"
module qpsr_top_tb;
  logic ref_clk, reset, bus_wr, bus_rd, bus_wr_allowed, irq;
  logic [`QPSR_AW-1:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic evt_push, evt_pop;
  logic [`QPSR_QW-1:0] evt_qid;
  logic [16:0] evt_size, evt_head_size;
  logic [15:0] queue_level_flag, level_pin;
  int failures = 0;
  int n_checks = 0;
  // ==========
  // Design, engine model, clock
  qpsr_top qpsr_top_inst (.ref_clk, .reset, .bus_wr, .bus_rd, .bus_addr,
    .bus_wdata, .bus_wr_allowed, .bus_rdata, .evt_push, .evt_pop, .evt_qid,
    .evt_size, .evt_head_size, .queue_level_flag, .level_pin, .irq);
  qpsr_engine_model qpsr_engine_model_inst (.ref_clk, .evt_push, .evt_pop,
    .evt_qid, .evt_size, .evt_head_size);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ==========
  // Helpers
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic ok);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr_allowed <= ok;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  // Read data judged in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk("read data", e, bus_rdata);
    @(posedge ref_clk);
  endtask
  task automatic complete_run;
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset_vals;
    wr(10'h030, 32'hFFFFFFFF, 1'b1);
    rd(10'h030, 32'h0);
    rd(10'h0FC, 32'h81);
    rd(10'h008, 32'h0);
    rd(10'h3F0, 32'h0);
    rd(`QPSR_OFF_CAPS, {16'h0, `QPSR_COUNT_CAPS});
  endtask
  task automatic t_counts;
    wr(10'h02C, 32'h81, 1'b1);
    qpsr_engine_model_inst.send(1'b1, 4'h2, 17'd100, 17'd100);
    qpsr_engine_model_inst.send(1'b1, 4'h2, 17'h1FFFF, 17'd100);
    rd(10'h020, 32'h2);
    rd(10'h024, 32'h00020063);
    rd(10'h028, 32'd100);
    chk("flag", 32'h4, {16'h0, queue_level_flag});
    qpsr_engine_model_inst.send(1'b0, 4'h2, 17'd100, 17'h1FFFF);
    rd(10'h028, 32'h1FFFF);
    rd(10'h024, 32'h1FFFF);
    qpsr_engine_model_inst.send(1'b0, 4'h2, 17'h1FFFF, 17'h0);
    rd(10'h020, 32'h0);
    chk("flag", 32'h0, {16'h0, queue_level_flag});
  endtask
  // Refused write, underflow, mask and read-clear
  task automatic t_irq;
    wr(`QPSR_OFF_IRQ_MASK, 32'h0, 1'b1);
    rd(`QPSR_OFF_IRQ_MASK, 32'h0);
    wr(10'h01C, 32'h0, 1'b0);
    rd(10'h01C, 32'h81);
    qpsr_engine_model_inst.send(1'b0, 4'h1, 17'h1, 17'h0);
    rd(10'h010, 32'h0);
    chk("irq masked", 32'h0, irq);
    wr(`QPSR_OFF_IRQ_MASK, 32'h4, 1'b1);
    rd(`QPSR_OFF_IRQ_MASK, 32'h4);
    chk("irq", 32'h1, irq);
    rd(`QPSR_OFF_IRQ_STAT, 32'h6);
    chk("irq cleared", 32'h0, irq);
  endtask
  // Every code and polarity through four pushes and four pops
  task automatic t_level;
    logic [9:0] thr;
    logic [3:0] q;
    logic f;
    int k;
    for (int c = 0; c < 32; c++) begin
      q = c[3:0];
      thr = q == 0 ? 10'h0 : q >= 4'hA ? 10'h3FF : (10'h1 << q) - 10'h1;
      wr({2'b0, q, 4'hC}, {24'hFFFFFF, c[4], 3'h7, q}, 1'b1);
      rd({2'b0, q, 4'hC}, {24'h0, c[4], 3'h0, q});
      for (int n = 1; n < 9; n++) begin
        qpsr_engine_model_inst.send(n < 5, q, 17'h1, 17'h1);
        k = n < 5 ? n : 8 - n;
        f = c[4] ? k >= thr : k < thr;
        chk("flag", f, queue_level_flag[q]);
        chk("pin", f && q < 8, level_pin[q]);
      end
    end
  endtask
  // ==========
  // Reset, scenarios, verdict
  initial begin
    {reset, bus_wr, bus_rd, bus_addr, bus_wdata, bus_wr_allowed} = '0;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_vals;
    t_counts;
    t_irq;
    t_level;
    complete_run;
  end
  // Hang limit
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
